/* File: verif/fast_osc_control_measure_tb_top.sv */
`timescale 1ns/100ps
module fast_osc_control_measure_tb_top;
    import foc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, sfr_wr_en = 1'b0, sfr_rd_en = 1'b0;
    logic startup_phase = 1'b0, dcdc_clk_request = 1'b0, dcdc_off = 1'b0;
    logic dcdc_standby = 1'b0, power_up_reset = 1'b0, port_write_req = 1'b0;
    logic code_fetch_req = 1'b0, osc_clk_in, ref_clk_in, osc_enable;
    logic fast_clk_ready, measure_busy, port_write_ack;
    logic external_program_read_strobe;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [4:0] oscillator_current_trim;
    int num_errors = 0, n_checks = 0, i, t;
    wire [2:0] flags = {measure_busy, external_program_read_strobe,
        fast_clk_ready};
    always #12.5 clk = ~clk;
    foc_fast_osc_control i_dut (.*);
    foc_osc_model i_osc (.*);
    task automatic chk(input logic [7:0] g, x);
        n_checks++;
        if (g !== x)
            $display("wrong value at %0t got %0h want %0h", $time, g, x);
        num_errors += int'(g !== x);
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr_en = 1'b1;
        @(negedge clk) sfr_wr_en = 1'b0;
    endtask
    // Tolerance covers the edge jitter of two synchronisers
    task automatic rd(input logic [7:0] a, x, input int tol = 0);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd_en = 1'b1;
        @(negedge clk) sfr_rd_en = 1'b0;
        chk((sfr_rdata + tol >= x && sfr_rdata <= x + tol) ? x : sfr_rdata, x);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wt(input int s, input logic v);
        for (i = 0; i < 2000 && flags[s] !== v; i++) @(negedge clk);
        num_errors += int'(i == 2000);
        if (i == 2000) report_and_stop();
    endtask
    initial
    begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        rd(CTRL_ADDR, 8'h00);
        rd(8'h55, 8'h00);
        chk(8'(oscillator_current_trim), 8'h10);
        startup_phase = 1'b1;
        @(negedge clk) chk(8'(osc_enable), 8'h01);
        {startup_phase, dcdc_clk_request} = 2'h1;
        @(negedge clk) chk(8'(osc_enable), 8'h01);
        dcdc_standby = 1'b1;
        @(negedge clk) chk(8'(osc_enable), 8'h00);
        wr(CTRL_ADDR, 8'hFE);
        rd(CTRL_ADDR, 8'hBE);
        chk(8'(oscillator_current_trim), 8'h0F);
        {port_write_req, code_fetch_req} = 2'h3;
        repeat (990) @(negedge clk);
        chk(8'(port_write_ack), 8'h00);
        wt(0, 1'b1);
        wt(1, 1'b1);
        chk(8'(port_write_ack), 8'h01);
        for (t = 0; t < 2; t++)
        begin
            wr(CTRL_ADDR, t ? 8'hBF : 8'h81);
            wr(CTRL_ADDR, t ? 8'hBE : 8'h80);
            chk(8'(measure_busy), 8'h01);
            wt(2, 1'b0);
            rd(COUNT_ADDR, 8'((6000000 - t * 200000) / 76800), 1);
        end
        wr(COUNT_ADDR, 8'h00);
        rd(COUNT_ADDR, 8'h4B, 1);
        dcdc_off = 1'b1;
        @(negedge clk) power_up_reset = 1'b1;
        @(negedge clk) power_up_reset = 1'b0;
        rd(CTRL_ADDR, 8'h3E);
        chk(8'(fast_clk_ready), 8'h00);
        report_and_stop();
    end
endmodule

/* File: verif/foc_osc_model.sv */
`timescale 1ns/100ps
module foc_osc_model (
    input wire logic osc_enable,
    input wire logic [foc_pkg::TRIM_W-1:0] oscillator_current_trim,
    output logic osc_clk_in,
    output logic ref_clk_in
);
    import foc_pkg::*;
    initial {osc_clk_in, ref_clk_in} = 2'h0;
    // Reference runs free, so every window closes
    always #6510.4 ref_clk_in = ~ref_clk_in;
    // Polls while stopped, so no wait is left open
    always
    begin
        if (osc_enable !== 1'b1)
            #10;
        else
        begin
            // 200 kHz a step, 6 MHz at code 10h
            #(5.0e8 / (6.0e6 + 2.0e5
                * ($itor(oscillator_current_trim) - 16.0)));
            osc_clk_in = ~osc_clk_in;
        end
    end
endmodule

/* File: verif/foc_sva.sv */
`timescale 1ns/100ps
module foc_sva (
    input logic clk,
    input logic rst,
    input logic sfr_wr_en,
    input logic startup_phase,
    input logic dcdc_clk_request,
    input logic dcdc_standby,
    input logic code_fetch_req,
    input logic port_write_req,
    input logic osc_enable,
    input logic fast_clk_ready,
    input logic port_write_ack,
    input logic measure_busy,
    input logic external_program_read_strobe,
    input logic [foc_pkg::ADDR_W-1:0] sfr_addr,
    input logic [foc_pkg::DATA_W-1:0] sfr_wdata,
    input logic [foc_pkg::TRIM_W-1:0] oscillator_current_trim
);
    import foc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Clock cycles in one reference period, rounded down
    localparam int REF_CYC = CLK_FREQ_HZ / REF_FREQ_HZ;
    // Slack for synchroniser delay at both ends of the start-up
    localparam int READY_MIN = 2 * REF_CYC - 4;
    localparam int READY_MAX = 3 * REF_CYC + 8;
    logic [11:0] on_cycles;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            on_cycles <= 12'h000;
        else if (!osc_enable)
            on_cycles <= 12'h000;
        else if (on_cycles != 12'hFFF)
            on_cycles <= on_cycles + 12'h001;
    end
    a_trim_map: assert property (
        sfr_wr_en && sfr_addr == CTRL_ADDR |=> oscillator_current_trim ==
        {~$past(sfr_wdata[5]), $past(sfr_wdata[4:1])}) else $error("trim");
    a_start_on: assert property (
        startup_phase |=> osc_enable) else $error("start");
    a_dcdc_on: assert property (
        dcdc_clk_request && !dcdc_standby |=> osc_enable) else $error("dcdc");
    a_ready_off: assert property (
        !osc_enable |=> !fast_clk_ready) else $error("ready");
    a_ready_late: assert property (
        $rose(osc_enable) |=> !fast_clk_ready [*8]) else $error("early");
    a_ready_window: assert property (
        $rose(fast_clk_ready) |-> on_cycles >= READY_MIN
        && on_cycles <= READY_MAX) else $error("ready window");
    a_port_ack: assert property (
        port_write_ack == (port_write_req && fast_clk_ready))
        else $error("ack");
    a_fetch_gate: assert property (
        external_program_read_strobe
        |-> $past(code_fetch_req && fast_clk_ready))
        else $error("strobe");
    a_meas_start: assert property (
        $rose(measure_busy) |->
        $past(sfr_wr_en && sfr_addr == CTRL_ADDR && sfr_wdata[0], 2))
        else $error("meas");
    c_ready: cover property ($rose(fast_clk_ready));
    c_meas: cover property ($fell(measure_busy));
    c_fetch: cover property (external_program_read_strobe);
endmodule
bind foc_fast_osc_control foc_sva i_sva (.*);

/* File: verilog/foc_fast_osc_control.sv */
`timescale 1ns/100ps
module foc_fast_osc_control (
    input wire logic clk,
    input wire logic rst,
    input wire logic [foc_pkg::ADDR_W-1:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic sfr_rd_en,
    input wire logic [foc_pkg::DATA_W-1:0] sfr_wdata,
    output logic [foc_pkg::DATA_W-1:0] sfr_rdata,
    input wire logic startup_phase,
    input wire logic dcdc_clk_request,
    input wire logic dcdc_standby,
    input wire logic dcdc_off,
    input wire logic power_up_reset,
    input wire logic osc_clk_in,
    input wire logic ref_clk_in,
    input wire logic port_write_req,
    input wire logic code_fetch_req,
    output logic osc_enable,
    output logic [foc_pkg::TRIM_W-1:0] oscillator_current_trim,
    output logic fast_clk_ready,
    output logic measure_busy,
    output logic port_write_ack,
    output logic external_program_read_strobe
);
    import foc_pkg::*;

    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] next_ctrl;
    logic [COUNT_W-1:0] fast_osc_measured_count;
    logic [COUNT_W-1:0] next_fast_osc_measured_count;
    logic [DATA_W-1:0] next_sfr_rdata;
    logic off_seen;
    logic next_off_seen;
    logic req_prev;
    logic next_req_prev;
    foc_meas_state_t state;
    foc_meas_state_t next_state;
    logic [1:0] startup_cnt;
    logic [1:0] next_startup_cnt;
    logic next_osc_enable;
    logic next_fast_clk_ready;
    logic next_strobe;
    logic [2:0] osc_sync;
    logic [2:0] ref_sync;
    logic [2:0] next_osc_sync;
    logic [2:0] next_ref_sync;
    logic [TRIM_W-1:0] next_trim;
    logic osc_rise;
    logic ref_rise;
    logic ctrl_wr;
    logic hw_request;

    // Second stage onward only; first stage feeds nothing else
    assign osc_rise = osc_sync[1] & ~osc_sync[2];
    assign ref_rise = ref_sync[1] & ~ref_sync[2];
    assign ctrl_wr = sfr_wr_en && (sfr_addr == CTRL_ADDR);
    assign hw_request = startup_phase
                        | (dcdc_clk_request & ~dcdc_standby);

    always_comb
    begin
        next_ctrl = ctrl;
        next_off_seen = off_seen | dcdc_off;
        if (ctrl_wr)
        begin
            next_ctrl = sfr_wdata;
            next_ctrl[6] = 1'b0;
        end
        // A power-up reset drops keep-on only after an off state
        if (power_up_reset && off_seen)
        begin
            next_ctrl[KEEP_ON_BIT] = 1'b0;
            next_off_seen = dcdc_off;
        end
        // Taken from the new value so trim moves with the register
        next_trim = {~next_ctrl[TRIM_MSB],
                     next_ctrl[TRIM_MSB-1:TRIM_LSB]};
    end

    always_comb
    begin
        next_osc_enable = hw_request | ctrl[KEEP_ON_BIT];
        next_startup_cnt = startup_cnt;
        next_fast_clk_ready = fast_clk_ready;
        if (!osc_enable)
        begin
            next_startup_cnt = 2'h0;
            next_fast_clk_ready = 1'b0;
        end
        else if (!fast_clk_ready && ref_rise)
        begin
            next_startup_cnt = startup_cnt + 2'h1;
            if (startup_cnt + 2'h1 == STARTUP_REF_EDGES)
            begin
                next_fast_clk_ready = 1'b1;
            end
        end
    end

    always_comb
    begin
        next_req_prev = ctrl[MEAS_REQ_BIT];
        next_state = state;
        next_fast_osc_measured_count = fast_osc_measured_count;
        case (state)
            FOC_MEAS_IDLE:
            begin
                // Bit is level; software must lower it again
                if (ctrl[MEAS_REQ_BIT] && !req_prev)
                begin
                    next_fast_osc_measured_count = COUNT_RESET;
                    next_state = FOC_MEAS_ARM;
                end
            end
            FOC_MEAS_ARM:
            begin
                if (ref_rise)
                begin
                    next_state = FOC_MEAS_COUNT;
                end
            end
            FOC_MEAS_COUNT:
            begin
                if (ref_rise)
                begin
                    next_state = FOC_MEAS_IDLE;
                end
                else if (osc_rise)
                begin
                    next_fast_osc_measured_count =
                        fast_osc_measured_count + 8'h01;
                end
            end
            default:
            begin
                next_state = FOC_MEAS_IDLE;
            end
        endcase
    end

    always_comb
    begin
        next_sfr_rdata = sfr_rdata;
        if (sfr_rd_en)
        begin
            case (sfr_addr)
                CTRL_ADDR: next_sfr_rdata = ctrl;
                COUNT_ADDR: next_sfr_rdata = fast_osc_measured_count;
                default: next_sfr_rdata = READ_UNMAPPED;
            endcase
        end
        // Strobe aligned to a fast clock edge; no clock means no strobe
        next_strobe = code_fetch_req & fast_clk_ready & osc_rise;
    end

    // Ack waits for the clock so a stopped oscillator stalls the write
    assign port_write_ack = port_write_req & fast_clk_ready;
    assign measure_busy = (state != FOC_MEAS_IDLE);

    always_comb
    begin
        next_osc_sync = {osc_sync[1:0], osc_clk_in};
        next_ref_sync = {ref_sync[1:0], ref_clk_in};
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= CTRL_RESET;
            off_seen <= 1'b0;
            oscillator_current_trim <= {~CTRL_RESET[TRIM_MSB],
                                        CTRL_RESET[TRIM_MSB-1:TRIM_LSB]};
        end
        else
        begin
            ctrl <= next_ctrl;
            off_seen <= next_off_seen;
            oscillator_current_trim <= next_trim;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            osc_enable <= 1'b0;
            startup_cnt <= 2'h0;
            fast_clk_ready <= 1'b0;
        end
        else
        begin
            osc_enable <= next_osc_enable;
            startup_cnt <= next_startup_cnt;
            fast_clk_ready <= next_fast_clk_ready;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            req_prev <= 1'b0;
            state <= FOC_MEAS_IDLE;
            fast_osc_measured_count <= COUNT_RESET;
        end
        else
        begin
            req_prev <= next_req_prev;
            state <= next_state;
            fast_osc_measured_count <= next_fast_osc_measured_count;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sfr_rdata <= READ_UNMAPPED;
            external_program_read_strobe <= 1'b0;
        end
        else
        begin
            sfr_rdata <= next_sfr_rdata;
            external_program_read_strobe <= next_strobe;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            osc_sync <= 3'h0;
            ref_sync <= 3'h0;
        end
        else
        begin
            osc_sync <= next_osc_sync;
            ref_sync <= next_ref_sync;
        end
    end
endmodule

/* File: verilog/foc_pkg.sv */
// Functional notes
// - Oscillator runs in start-up, on converter request, or with keep-on enable set.
// - Converter in standby mode never requests the oscillator.
// - Keep-on cleared only by write of 0, or power-up reset after converter off.
// - Fast clock marked available only after two to three reference periods.
// - A 5-bit trim code drives the ring oscillator current; smaller is slower.
// - Top trim bit stored inverted so all-zero register gives nominal frequency.
// - Request clears counter, counts between two reference rising edges.
// - Rising edge of request bit starts one measurement of one reference period.
// - Count readable by processor; frequency is count times 76800 Hz.
// - Port writes and external fetch strobes wait for a running fast clock.
package foc_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int TRIM_W = 5;
    localparam int COUNT_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'hD3;
    localparam logic [ADDR_W-1:0] COUNT_ADDR = 8'hD4;
    localparam int KEEP_ON_BIT = 7;
    localparam int TRIM_LSB = 1;
    localparam int TRIM_MSB = 5;
    localparam int MEAS_REQ_BIT = 0;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;
    localparam int REF_FREQ_HZ = 76800;
    localparam int CLK_FREQ_HZ = 40000000;
    // Edges counted from an arbitrary phase: 3 edges span 2 to 3 periods
    localparam logic [1:0] STARTUP_REF_EDGES = 2'h3;
    typedef enum logic [2:0] {
        FOC_MEAS_IDLE = 3'b001,
        FOC_MEAS_ARM = 3'b010,
        FOC_MEAS_COUNT = 3'b100
    } foc_meas_state_t;
endpackage
